// [sim/sadc_ana_model.sv]
// Behavioural analog multiplexer and comparator facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module sadc_ana_model (
	input  wire logic       clock_i,     // System clock.
	input  wire logic [9:0] dac_code_i,  // Trial code from the sequencer.
	input  wire logic [3:0] mux_sel_i,   // Channel select.
	input  wire logic       analog_en_i, // Analog core power.
	output logic            cmp_o        // Input at or above trial code.
);
	// Levels run past full scale so saturation can be provoked.
	logic [10:0] lvl [16];
	logic        tgl = 1'b0;

	always @(posedge clock_i) begin
		tgl <= ~tgl;
	end

	// A powered-down core gives no usable decision, so it chatters.
	assign cmp_o = analog_en_i ? (lvl[mux_sel_i] >= {1'b0, dac_code_i})
	                           : tgl;
endmodule // sadc_ana_model
`default_nettype wire

// [sim/sadc_seq_asserts.sv]
// Bus and register-map checks bound to the sequencer top.
`timescale 1ns/1ps
`default_nettype none
module sadc_seq_asserts #(
	parameter CHW = 4
) (
	input wire logic           clock_i,       // Clock.
	input wire logic           arst_n_i,      // Reset, active low.
	input wire logic           s_axi_awvalid, // Write address valid.
	input wire logic           s_axi_awready, // Write address ready.
	input wire logic           s_axi_bvalid,  // Write response valid.
	input wire logic           s_axi_arvalid, // Read address valid.
	input wire logic           s_axi_arready, // Read address ready.
	input wire logic [3:0]     s_axi_araddr,  // Read address.
	input wire logic           s_axi_rvalid,  // Read data valid.
	input wire logic           s_axi_rready,  // Read data ready.
	input wire logic [31:0]    s_axi_rdata,   // Read data.
	input wire logic [1:0]     s_axi_rresp,   // Read response.
	input wire logic [CHW-1:0] mux_sel_o,     // Mux select.
	input wire logic           analog_en_o    // Analog power.
);
	logic [3:0] a_q;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) a_q <= 4'h0;
		else if (s_axi_arvalid && s_axi_arready) a_q <= s_axi_araddr;
	end

	AST_RD_ANSWER:
	assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	AST_WR_ANSWER:
	assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
		else $error("write answer missing");
	AST_R_HOLD:
	assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
	AST_B_BLOCK:
	assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while pending");
	AST_R_BLOCK:
	assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while pending");
	AST_LOW_ZERO:
	assert property (s_axi_rvalid && a_q == 4'h8 |-> s_axi_rdata[31:2] == 0)
		else $error("low result upper bits set");
	AST_HIGH_ZERO:
	assert property (s_axi_rvalid && a_q == 4'h4 |-> s_axi_rdata[31:8] == 0)
		else $error("high result upper bits set");
	AST_UNMAPPED:
	assert property (s_axi_rvalid && a_q[1:0] != 2'h0
		|-> s_axi_rresp == 2'h2 && s_axi_rdata == 0) else $error("bad unmapped");
	AST_CSR_CH:
	assert property (s_axi_rvalid && a_q == 4'h0
		|-> s_axi_rdata[3:0] == mux_sel_o && !s_axi_rdata[4])
		else $error("channel field differs from mux");
	cover property (s_axi_bvalid);
	cover property (s_axi_rvalid && a_q == 4'h4);
	cover property ($rose(analog_en_o));
endmodule // sadc_seq_asserts

bind sadc_seq sadc_seq_asserts #(.CHW(CHW)) chk_u (
	.clock_i(clock_i), .arst_n_i(arst_n_i), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .mux_sel_o(mux_sel_o),
	.analog_en_o(analog_en_o));
`default_nettype wire

// [sim/sadc_tb.sv]
// Register-level bench for the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clock_i, arst_n_i, awv, awr, wv, wrd, bv, br;
	logic        arv, arr, rv, rr, cmp, aen;
	logic [3:0]  awa, ara, mux;
	logic [31:0] wd, rdt, v;
	logic [1:0]  bs, rs, rs_v;
	logic [9:0]  dac, e;
	logic [3:0]  ch [4] = '{4'h0, 4'h5, 4'hf, 4'h9};
	logic [10:0] lv [4] = '{11'h000, 11'h7ff, 11'h2a5, 11'h155};
	int          bad_count, samples_checked, i;

	sadc_seq #(.STAB_CYC(4)) dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_bresp(bs), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.s_axi_rdata(rdt), .s_axi_rresp(rs), .cmp_i(cmp),
		.dac_code_o(dac), .mux_sel_o(mux), .analog_en_o(aen));
	sadc_ana_model model_u (.clock_i(clock_i), .dac_code_i(dac),
		.mux_sel_i(mux), .analog_en_i(aen), .cmp_o(cmp));

	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = ~clock_i;
	end

	task close_out;
		if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task limit(input int n);
		if (n >= 60) begin
			bad_count++;
			close_out;
		end
	endtask
	// Handshakes are judged at the falling edge, so the rising edge that
	// takes an item is known before anything is released after it.
	task wr(input logic [3:0] a, input logic [31:0] d);
		int   n;
		logic ta, tw;
		awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; n = 0;
		ta = 1'b0;
		tw = 1'b0;
		do begin
			@(negedge clock_i); n++;
			if (awv && awr === 1'b1) ta = 1'b1;
			if (wv && wrd === 1'b1) tw = 1'b1;
			@(posedge clock_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!(ta && tw) && n < 60);
		br <= 1'b1;
		do begin @(negedge clock_i); n++; end while (bv !== 1'b1 && n < 60);
		@(posedge clock_i);
		br <= 1'b0;
		limit(n);
	endtask
	// Ready is raised a cycle late so the slave must hold its answer.
	task rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		arv <= 1'b1; ara <= a; n = 0;
		do begin @(negedge clock_i); n++; end while (arr !== 1'b1 && n < 60);
		@(posedge clock_i);
		arv <= 1'b0;
		@(posedge clock_i);
		rr <= 1'b1;
		do begin @(negedge clock_i); n++; end while (rv !== 1'b1 && n < 60);
		d = rdt;
		rs_v = rs;
		@(posedge clock_i);
		rr <= 1'b0;
		limit(n);
	endtask
	task poll;
		int n;
		n = 0;
		do begin rd(4'h0, v); n++; end while (v[7] !== 1'b1 && n < 60);
		limit(n);
	endtask

	initial begin
		arst_n_i = 0; awv = 0; wv = 0; br = 0; arv = 0; rr = 0;
		awa = 0; ara = 0; wd = 0;
		repeat (16) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		for (i = 0; i < 3; i++) begin rd(i * 4, v); chk(v, 0); end
		rd(4'h1, v); chk({rs_v, v[29:0]}, 32'h80000000);
		wr(4'hc, 32'h2);
		for (i = 0; i < 4; i++) begin
			model_u.lvl[ch[i]] = lv[i];
			e = (lv[i] > 11'h3ff) ? 10'h3ff : lv[i][9:0];
			if (i == 0) wr(4'h0, {28'h0, ch[i]});
			wr(4'h0, 32'h20 | ch[i]);
			poll;
			rd(4'h8, v); chk(v, {30'h0, e[1:0]});
			rd(4'h4, v); chk(v, {24'h0, e[9:2]});
			rd(4'h0, v); chk(v, 32'h20 | ch[i]);
			chk(mux, ch[i]);
			poll; wr(4'h0, 32'h20 | ch[i]);
			rd(4'h0, v); chk(v, 32'h20 | ch[i]);
		end
		wr(4'h0, 32'h69); poll;
		rd(4'h4, v); chk(v, {24'h0, e[9:2]});
		wr(4'h0, 32'h09);
		@(negedge clock_i);
		chk(aen, 0);
		repeat (60) @(posedge clock_i);
		rd(4'h0, v); chk(v, 32'h09);
		wr(4'h0, 32'h29); wr(4'hc, 32'h1);
		@(negedge clock_i);
		chk(aen, 0);
		wr(4'hc, 32'h0);
		repeat (8) @(posedge clock_i);
		rd(4'hc, v); chk(v, 32'h4);
		chk(aen, 1);
		close_out;
	end
endmodule // testbench
`default_nettype wire

// [src/sadc_defines.vh]
// Constants shared by the converter sequencer and its comparator stepper.
`ifndef SADC_DEFINES_VH
`define SADC_DEFINES_VH

`define SADC_OFF_CSR      4'h0
`define SADC_OFF_HIGH     4'h4
`define SADC_OFF_LOW      4'h8
`define SADC_OFF_MODE     4'hc

`define SADC_CSR_DONE     7
`define SADC_CSR_SPEED    6
`define SADC_CSR_ON       5
`define SADC_CSR_CH_HI    3
`define SADC_CSR_CH_LO    0

`define SADC_MODE_HALT    0
`define SADC_MODE_WAIT    1
`define SADC_MODE_STABLE  2

`define SADC_RES_BITS     10
`define SADC_CH_BITS      4
`define SADC_NUM_CH       16

`define SADC_DIV_SLOW     3'h4
`define SADC_DIV_FAST     3'h2

`define SADC_STAB_NS      2000
`define SADC_CLK_NS       25
`define SADC_STAB_CYC     ((`SADC_STAB_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)

`define SADC_RESP_OKAY    2'h0
`define SADC_RESP_SLVERR  2'h2

`endif

// [src/sadc_sar_step.v]
// Successive-approximation stepper: one comparator decision per result bit.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_defines.vh"

module sadc_sar_step #(
	parameter W = `SADC_RES_BITS
) (
	input  wire         clock_i,  // System clock.
	input  wire         arst_n_i, // Asynchronous reset, active low.
	input  wire         start_i,  // Begin a fresh conversion.
	input  wire         abort_i,  // Drop the conversion in flight.
	input  wire         tick_i,   // Converter clock enable pulse.
	input  wire         cmp_i,    // Comparator: input at or above trial code.
	output reg  [W-1:0] trial_o,  // Trial code driven to the DAC.
	output reg  [W-1:0] result_o, // Finished code.
	output reg          done_o,   // One-cycle pulse when finished.
	output reg          busy_o    // Conversion in progress.
);
	reg [W-1:0] bit_q;

	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			trial_o  <= {W{1'b0}};
			result_o <= {W{1'b0}};
			done_o   <= 1'b0;
			busy_o   <= 1'b0;
			bit_q    <= {W{1'b0}};
		end else begin
			done_o <= 1'b0;
			if (abort_i) begin
				busy_o  <= 1'b0;
				trial_o <= {W{1'b0}};
			end else if (start_i) begin
				busy_o  <= 1'b1;
				bit_q   <= {1'b1, {(W-1){1'b0}}}; // [R21]
				trial_o <= {1'b1, {(W-1){1'b0}}};
			end else if (busy_o && tick_i) begin
				// Keeping the bit only when the input is at or above the trial
				// makes the code monotonic and saturates at both ends.
				if (bit_q[0]) begin // [R21]
					busy_o   <= 1'b0;
					done_o   <= 1'b1;
					result_o <= cmp_i ? trial_o : (trial_o & ~bit_q); // [R04]
				end else begin
					trial_o <= (cmp_i ? trial_o : (trial_o & ~bit_q))
						| (bit_q >> 1); // [R04]
					bit_q   <= bit_q >> 1;
				end
			end
		end
	end
endmodule // sadc_sar_step

`default_nettype wire

// [src/sadc_seq.v]
// Converter sequencer top: AXI4-Lite registers, channel mux and SAR control.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_defines.vh"

// How it works
// R01: Ten-bit unsigned result kept in register pair.
// R02: Input above reference saturates to all ones.
// R03: Input below low reference reads zero.
// R04: Output code follows input monotonically.
// R05: Sixteen channels; selected one is converted.
// R06: Software picks channel before enabling.
// R07: On bit starts continuous back-to-back conversion.
// R08: Each finish updates result and sets done.
// R09: Reading high result clears done flag.
// R10: Software reads low, then high, after done.
// R11: Software reads both halves before next finish.
// R12: Eight-bit use reads only high register.
// R13: Channel change aborts, clears done, restarts.
// R14: Clearing on bit stops and powers down.
// R15: Wait mode leaves conversion running.
// R16: Halt disables; stabilization follows wake-up.
// R17: Any control write clears done flag; the code clears it on CSR writes only, not on mode writes.
// R18: High register holds bits nine to two.
// R19: Low register holds bits one, zero.
// R20: Channel field is plain binary input number.
// R21: Fixed step count, one per bit, MSB first.
// R22: No interrupt; done flag is polled.
module sadc_seq #(
	parameter W         = `SADC_RES_BITS,
	parameter CHW       = `SADC_CH_BITS,
	parameter STAB_CYC  = `SADC_STAB_CYC
) (
	input  wire           clock_i,       // 40 MHz system clock.
	input  wire           arst_n_i,      // Asynchronous reset, active low.
	input  wire           s_axi_awvalid, // Write address valid.
	output reg            s_axi_awready, // Write address ready.
	input  wire [3:0]     s_axi_awaddr,  // Write byte address.
	input  wire           s_axi_wvalid,  // Write data valid.
	output reg            s_axi_wready,  // Write data ready.
	input  wire [31:0]    s_axi_wdata,   // Write data.
	input  wire [3:0]     s_axi_wstrb,   // Write byte strobes.
	output reg            s_axi_bvalid,  // Write response valid.
	input  wire           s_axi_bready,  // Write response ready.
	output reg  [1:0]     s_axi_bresp,   // Write response code.
	input  wire           s_axi_arvalid, // Read address valid.
	output reg            s_axi_arready, // Read address ready.
	input  wire [3:0]     s_axi_araddr,  // Read byte address.
	output reg            s_axi_rvalid,  // Read data valid.
	input  wire           s_axi_rready,  // Read data ready.
	output reg  [31:0]    s_axi_rdata,   // Read data.
	output reg  [1:0]     s_axi_rresp,   // Read response code.
	input  wire           cmp_i,         // Comparator decision.
	output reg  [W-1:0]   dac_code_o,    // Trial code to the DAC.
	output reg  [CHW-1:0] mux_sel_o,     // Analog mux select.
	output reg            analog_en_o    // Powers the analog core.
);
	// Registers and state.
	reg           converter_on_q;
	reg           speed_q;
	reg [CHW-1:0] channel_select_q;
	reg           done_q;
	reg [W-1:0]   result_q;
	reg           halt_q;
	reg           wait_q;
	reg [15:0]    stab_q;
	reg [2:0]     div_q;
	reg           aw_q;
	reg           w_q;
	reg [3:0]     awaddr_q;
	reg [31:0]    wdata_q;
	reg [3:0]     wstrb_q;
	reg           restart_q;

	wire [W-1:0] sar_trial;
	wire [W-1:0] sar_result;
	wire         sar_done;
	wire         sar_busy;

	wire active    = converter_on_q && !halt_q; // [R14] [R16] [R15]
	wire stable    = (stab_q == 16'h0000);
	wire [2:0] div_top = speed_q ? `SADC_DIV_FAST : `SADC_DIV_SLOW;
	wire tick      = (div_q == div_top - 3'h1);
	wire do_write  = aw_q && w_q && !s_axi_bvalid;
	wire wr_csr    = do_write && (awaddr_q == `SADC_OFF_CSR) && wstrb_q[0];
	wire wr_mode   = do_write && (awaddr_q == `SADC_OFF_MODE) && wstrb_q[0];
	wire do_read   = s_axi_arvalid && s_axi_arready;
	wire rd_high   = do_read && (s_axi_araddr == `SADC_OFF_HIGH);
	wire [CHW-1:0] new_ch = wdata_q[`SADC_CSR_CH_HI:`SADC_CSR_CH_LO];
	wire ch_change = wr_csr && (new_ch != channel_select_q);
	wire start     = active && !sar_busy && !ch_change
		&& (restart_q || !sar_done);
	wire abort     = !active || ch_change;                  // [R13] [R14]

	sadc_sar_step #(
		.W(W)
	) u_step (
		.clock_i  (clock_i),
		.arst_n_i (arst_n_i),
		.start_i  (start),
		.abort_i  (abort),
		.tick_i   (tick),
		.cmp_i    (cmp_i),
		.trial_o  (sar_trial),
		.result_o (sar_result),
		.done_o   (sar_done),
		.busy_o   (sar_busy)
	);

	// Converter clock divider: cpu/4 or cpu/2 as the speed bit asks.
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q <= 3'h0;
		end else if (!sar_busy || tick) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_q + 3'h1;
		end
	end

	// Control state, done flag and result capture.
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			converter_on_q   <= 1'b0;
			speed_q          <= 1'b0;
			channel_select_q <= {CHW{1'b0}};
			done_q           <= 1'b0;
			result_q         <= {W{1'b0}};
			halt_q           <= 1'b0;
			wait_q           <= 1'b0;
			stab_q           <= 16'h0000;
			restart_q        <= 1'b0;
		end else begin
			restart_q <= 1'b0;
			if (wr_csr) begin
				converter_on_q   <= wdata_q[`SADC_CSR_ON];   // [R07] [R14]
				speed_q          <= wdata_q[`SADC_CSR_SPEED];
				channel_select_q <= new_ch;                  // [R05] [R20]
			end
			if (wr_mode) begin
				halt_q <= wdata_q[`SADC_MODE_HALT];
				wait_q <= wdata_q[`SADC_MODE_WAIT];          // [R15]
				if (halt_q && !wdata_q[`SADC_MODE_HALT]) begin
					stab_q <= STAB_CYC[15:0];                // [R16]
				end
			end else if (!stable) begin
				stab_q <= stab_q - 16'h0001;
			end
			if (sar_done && active) begin
				result_q  <= sar_result;                     // [R01] [R08]
				restart_q <= 1'b1;                           // [R07]
			end
			// A finishing conversion wins over a clearing read.
			if (sar_done && active && !ch_change) begin
				done_q <= 1'b1;                              // [R08]
			end else if (wr_csr || rd_high || ch_change) begin
				done_q <= 1'b0;                              // [R09] [R13] [R17]
			end
		end
	end

	// Analog side outputs, registered.
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dac_code_o  <= {W{1'b0}};
			mux_sel_o   <= {CHW{1'b0}};
			analog_en_o <= 1'b0;
		end else begin
			dac_code_o  <= sar_trial;
			mux_sel_o   <= channel_select_q;                 // [R05]
			analog_en_o <= active;                           // [R14] [R16]
		end
	end

	// AXI4-Lite write channel; address and data accepted in either order.
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_q          <= 1'b0;
			w_q           <= 1'b0;
			awaddr_q      <= 4'h0;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SADC_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q          <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q          <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_q         <= 1'b0;
				w_q          <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == `SADC_OFF_CSR
					|| awaddr_q == `SADC_OFF_MODE
					|| awaddr_q == `SADC_OFF_HIGH
					|| awaddr_q == `SADC_OFF_LOW)
					? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel. The pair is not latched: software must take
	// both halves before the next finish, a trade for zero extra storage.
	always @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SADC_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (do_read) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= `SADC_RESP_OKAY;
				case (s_axi_araddr)
				`SADC_OFF_CSR: begin
					s_axi_rdata <= {24'h000000, done_q, speed_q,
						converter_on_q, 1'b0, channel_select_q}; // [R22]
				end
				`SADC_OFF_HIGH: begin
					s_axi_rdata <= {24'h000000, result_q[W-1:2]}; // [R18] [R02]
				end
				`SADC_OFF_LOW: begin
					s_axi_rdata <= {30'h00000000, result_q[1:0]}; // [R19] [R03]
				end
				`SADC_OFF_MODE: begin
					s_axi_rdata <= {29'h00000000, stable, wait_q, halt_q};
				end
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `SADC_RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // sadc_seq

`default_nettype wire
